// >>> rtl/pps_pkg.sv
// Package for the converter supervision and sensing block.
// Assumes a single 125 MHz clock and AXI4-Lite register access.
package pps_pkg;
    localparam int DW = 16;
    localparam int CLK_MHZ = 125;
    localparam int DEMAG_MIN_NS = 2000;
    localparam int DEMAG_MIN_CYC = (DEMAG_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_VIN_UV = 8'h04;
    localparam logic [7:0] A_VIN_OV = 8'h08;
    localparam logic [7:0] A_START_MIN = 8'h0C;
    localparam logic [7:0] A_START_MAX = 8'h10;
    localparam logic [7:0] A_BLANK_UV = 8'h14;
    localparam logic [7:0] A_BLANK_OV = 8'h18;
    localparam logic [7:0] A_BLANK_OC2 = 8'h1C;
    localparam logic [7:0] A_BLANK_CCM = 8'h20;
    localparam logic [7:0] A_SS_MAX = 8'h24;
    localparam logic [7:0] A_TRIP = 8'h28;
    localparam logic [7:0] A_SCALE = 8'h2C;
    localparam logic [7:0] A_FAULT = 8'h30;
    localparam logic [7:0] A_VOUT = 8'h34;
    localparam logic [7:0] A_IOUT = 8'h38;
    localparam logic [7:0] A_IPK = 8'h3C;
    localparam logic [7:0] A_VOUT_OFS = 8'h40;
    localparam logic [7:0] A_PDC = 8'h44;
    localparam logic [7:0] A_STATUS = 8'h48;
    localparam int F_UV = 0;
    localparam int F_OV = 1;
    localparam int F_OC2 = 2;
    localparam int F_CCM = 3;
    localparam int F_SS = 4;
    localparam int NFLT = 5;
    localparam logic [DW-1:0] OC2_FIXED = 16'hE000;
    localparam logic [DW-1:0] RST_BLANK = 16'h0100;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    typedef struct packed {
        logic [DW-1:0] vin_rms;
        logic [DW-1:0] pfc_cs;
        logic zcd_osc;
        logic max_period_on;
        logic ss_tick;
        logic ss_done;
    } pps_pfc_t;
    typedef struct packed {
        logic [DW-1:0] cs_sample;
        logic [DW-1:0] zcd_sample;
        logic [DW-1:0] t_on;
        logic [DW-1:0] t_demag;
        logic [DW-1:0] t_period;
        logic [7:0] n_pulses;
        logic burst;
        logic cycle_done;
    } pps_fb_t;
endpackage

// >>> rtl/pps_top.sv
// Protection timers and flyback output estimation with AXI4-Lite registers.
// Assumes sampled analog inputs are synchronous to clk.
// Overview of operation
// - Input undervoltage fires after blanking expires
// - Input overvoltage fires after blanking expires
// - Separate start-up min/max thresholds gate stage two
// - High current sense triggers second overcurrent
// - Shorted sense shows as missing oscillation
// - Conduction guard disarmed during soft start
// - Flag timeout turn-on without oscillation
// - Missing oscillation beyond blanking trips guard
// - Soft-start count at maximum trips failure
// - Software sets flyback peak current trip
// - Sense sample taken before gate turn-off
// - Peak current with delay compensation ratio
// - Zero-crossing sample at demagnetization end
// - Output voltage scaled plus offset
// - Output voltage drives loops and checks
// - Output current, valley and discontinuous modes
// - Output current in burst mode
// - Output current drives loops and checks
// - Discontinuous mode delays turn-on past valley
// - Faults except soft start fire only after full blanking
// - Second overcurrent uses fixed threshold
`timescale 1ns/1ps
module pps_top #(
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pps_pkg::pps_pfc_t pfc_in,
    input wire pps_pkg::pps_fb_t fb_in,
    output logic [15:0] peak_current_trip_level,
    output logic stage2_start_ok,
    output logic valley_skip,
    output logic [pps_pkg::NFLT-1:0] fault_flags,
    output logic [15:0] vout_value,
    output logic [15:0] iout_value,
    output logic result_valid
);
    import pps_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CALC = 3'b010,
        ST_DONE = 3'b100
    } pps_calc_t;

    logic [15:0] ctrl_ff, vin_uv_ff, vin_ov_ff, st_min_ff, st_max_ff;
    logic [15:0] bl_uv_ff, bl_ov_ff, bl_oc2_ff, bl_ccm_ff, ss_max_ff;
    logic [15:0] scale_ff, vofs_ff, pdc_ff, trip_ff;
    logic [15:0] cnt_uv_ff, cnt_ov_ff, cnt_oc2_ff, cnt_ccm_ff, ss_cnt_ff;
    logic [NFLT-1:0] flt_ff;
    logic [NFLT-1:0] evt;
    logic [NFLT-1:0] ack;
    logic cond_uv, cond_ov, cond_oc2, cond_ccm;
    logic ccm_turnon_ff;
    logic [15:0] ipk_ff, vout_ff, iout_ff;
    logic [31:0] ipk_w, vout_w, iout_w;
    logic [15:0] on_den;
    logic [15:0] period_sel;
    logic demag_short_ff;
    logic valid_ff;
    pps_calc_t st_ff;
    logic aw_ok_ff, w_ok_ff, ws_ok_ff;
    logic [7:0] awa_ff;
    logic [31:0] wd_ff;
    logic wr_go;

    function automatic logic [15:0] blank_next(input logic cond,
        input logic [15:0] cnt, input logic [15:0] lim);
        if (!cond)
            blank_next = 16'h0000;
        else if (cnt < lim)
            blank_next = cnt + 16'h0001;
        else
            blank_next = cnt;
    endfunction

    // Fault conditions
    assign cond_uv = pfc_in.vin_rms < vin_uv_ff;
    assign cond_ov = pfc_in.vin_rms > vin_ov_ff;
    assign cond_oc2 = pfc_in.pfc_cs >= OC2_FIXED;
    assign cond_ccm = ccm_turnon_ff && pfc_in.ss_done;
    // Start-up window between separate min and max thresholds, no hysteresis
    assign stage2_start_ok = (pfc_in.vin_rms >= st_min_ff) &&
        (pfc_in.vin_rms <= st_max_ff);
    // Timeout turn-on without oscillation marks conduction
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            ccm_turnon_ff <= 1'b0;
        else if (pfc_in.zcd_osc)
            ccm_turnon_ff <= 1'b0;
        else if (pfc_in.max_period_on)
            ccm_turnon_ff <= 1'b1;
    end

    // Blanking timers restart on clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_uv_ff <= 16'h0000;
            cnt_ov_ff <= 16'h0000;
            cnt_oc2_ff <= 16'h0000;
            cnt_ccm_ff <= 16'h0000;
        end else begin
            cnt_uv_ff <= blank_next(cond_uv, cnt_uv_ff, bl_uv_ff);
            cnt_ov_ff <= blank_next(cond_ov, cnt_ov_ff, bl_ov_ff);
            cnt_oc2_ff <= blank_next(cond_oc2, cnt_oc2_ff, bl_oc2_ff);
            cnt_ccm_ff <= blank_next(cond_ccm, cnt_ccm_ff, bl_ccm_ff);
        end
    end

    // Soft-start duration counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            ss_cnt_ff <= 16'h0000;
        else if (pfc_in.ss_done)
            ss_cnt_ff <= 16'h0000;
        else if (pfc_in.ss_tick && ss_cnt_ff < ss_max_ff)
            ss_cnt_ff <= ss_cnt_ff + 16'h0001;
    end
    assign evt[F_UV] = cond_uv && cnt_uv_ff == bl_uv_ff;
    assign evt[F_OV] = cond_ov && cnt_ov_ff == bl_ov_ff;
    assign evt[F_OC2] = cond_oc2 && cnt_oc2_ff == bl_oc2_ff;
    assign evt[F_CCM] = cond_ccm && cnt_ccm_ff == bl_ccm_ff;
    assign evt[F_SS] = !pfc_in.ss_done && ss_cnt_ff == ss_max_ff;
    assign ack = (wr_go && awa_ff == A_FAULT) ? wd_ff[NFLT-1:0] : '0;
    // Sticky flags, set wins over clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            flt_ff <= '0;
        else
            flt_ff <= (flt_ff & ~ack) | evt;
    end
    assign fault_flags = flt_ff;

    // Flyback estimation
    assign on_den = (fb_in.t_on > scale_ff[7:0]) ?
        fb_in.t_on - {8'h00, scale_ff[7:0]} : 16'h0001;
    assign period_sel = (fb_in.t_period == 16'h0000) ? 16'h0001 :
        fb_in.t_period;
    always_comb begin
        ipk_w = 32'(fb_in.cs_sample) * 32'(fb_in.t_on + pdc_ff)
            / 32'(on_den);
        vout_w = ((32'(fb_in.zcd_sample) * 32'(scale_ff[15:8])) >> 4)
            + 32'(vofs_ff);
        if (fb_in.burst)
            iout_w = (32'(ipk_ff) * 32'(fb_in.t_demag) * 32'(fb_in.n_pulses))
                / (32'(period_sel) << 1);
        else
            iout_w = (32'(ipk_ff) * 32'(fb_in.t_demag))
                / (32'(period_sel) << 1);
    end
    // Sequencing: sample at cycle end, then compute
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= ST_IDLE;
            ipk_ff <= 16'h0000;
            vout_ff <= 16'h0000;
            iout_ff <= 16'h0000;
            valid_ff <= 1'b0;
            demag_short_ff <= 1'b0;
        end else begin
            valid_ff <= 1'b0;
            case (st_ff)
                ST_IDLE: begin
                    if (fb_in.cycle_done) begin
                        ipk_ff <= ipk_w[15:0];
                        demag_short_ff <= fb_in.t_demag <
                            16'(DEMAG_MIN_CYC);
                        if (fb_in.t_demag >= 16'(DEMAG_MIN_CYC))
                            vout_ff <= vout_w[15:0];
                        st_ff <= ST_CALC;
                    end
                end
                ST_CALC: begin
                    iout_ff <= iout_w[15:0];
                    st_ff <= ST_DONE;
                end
                ST_DONE: begin
                    valid_ff <= 1'b1;
                    st_ff <= ST_IDLE;
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end
    assign vout_value = vout_ff;
    assign iout_value = iout_ff;
    assign result_valid = valid_ff;
    assign valley_skip = ctrl_ff[0];
    assign peak_current_trip_level = trip_ff;
    // AXI4-Lite write path
    assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_ok_ff && !s_axi_bvalid;
    assign wr_go = aw_ok_ff && w_ok_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff <= 32'h00000000;
            ws_ok_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_ff <= 1'b1;
                awa_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_ff <= 1'b1;
                wd_ff <= s_axi_wdata;
                ws_ok_ff <= s_axi_wstrb[1:0] == 2'b11;
            end
            if (wr_go) begin
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awa_ff <= A_STATUS && awa_ff[1:0] == 2'b00)
                    ? RESP_OK : RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= 16'h0000;
            vin_uv_ff <= 16'h0000;
            vin_ov_ff <= 16'hFFFF;
            st_min_ff <= 16'h0000;
            st_max_ff <= 16'hFFFF;
            bl_uv_ff <= RST_BLANK;
            bl_ov_ff <= RST_BLANK;
            bl_oc2_ff <= RST_BLANK;
            bl_ccm_ff <= RST_BLANK;
            ss_max_ff <= 16'hFFFF;
            trip_ff <= 16'h0000;
            scale_ff <= 16'h1000;
            vofs_ff <= 16'h0000;
            pdc_ff <= 16'h0000;
        end else if (wr_go && ws_ok_ff) begin
            case (awa_ff)
                A_CTRL: ctrl_ff <= wd_ff[15:0];
                A_VIN_UV: vin_uv_ff <= wd_ff[15:0];
                A_VIN_OV: vin_ov_ff <= wd_ff[15:0];
                A_START_MIN: st_min_ff <= wd_ff[15:0];
                A_START_MAX: st_max_ff <= wd_ff[15:0];
                A_BLANK_UV: bl_uv_ff <= wd_ff[15:0];
                A_BLANK_OV: bl_ov_ff <= wd_ff[15:0];
                A_BLANK_OC2: bl_oc2_ff <= wd_ff[15:0];
                A_BLANK_CCM: bl_ccm_ff <= wd_ff[15:0];
                A_SS_MAX: ss_max_ff <= wd_ff[15:0];
                A_TRIP: trip_ff <= wd_ff[15:0];
                A_SCALE: scale_ff <= wd_ff[15:0];
                A_VOUT_OFS: vofs_ff <= wd_ff[15:0];
                A_PDC: pdc_ff <= wd_ff[15:0];
                default: ;
            endcase
        end
    end

    // AXI4-Lite read path
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OK;
            case (s_axi_araddr)
                A_CTRL: s_axi_rdata <= {16'h0000, ctrl_ff};
                A_VIN_UV: s_axi_rdata <= {16'h0000, vin_uv_ff};
                A_VIN_OV: s_axi_rdata <= {16'h0000, vin_ov_ff};
                A_START_MIN: s_axi_rdata <= {16'h0000, st_min_ff};
                A_START_MAX: s_axi_rdata <= {16'h0000, st_max_ff};
                A_BLANK_UV: s_axi_rdata <= {16'h0000, bl_uv_ff};
                A_BLANK_OV: s_axi_rdata <= {16'h0000, bl_ov_ff};
                A_BLANK_OC2: s_axi_rdata <= {16'h0000, bl_oc2_ff};
                A_BLANK_CCM: s_axi_rdata <= {16'h0000, bl_ccm_ff};
                A_SS_MAX: s_axi_rdata <= {16'h0000, ss_max_ff};
                A_TRIP: s_axi_rdata <= {16'h0000, trip_ff};
                A_SCALE: s_axi_rdata <= {16'h0000, scale_ff};
                A_FAULT: s_axi_rdata <= {27'h0, flt_ff};
                A_VOUT: s_axi_rdata <= {16'h0000, vout_ff};
                A_IOUT: s_axi_rdata <= {16'h0000, iout_ff};
                A_IPK: s_axi_rdata <= {16'h0000, ipk_ff};
                A_VOUT_OFS: s_axi_rdata <= {16'h0000, vofs_ff};
                A_PDC: s_axi_rdata <= {16'h0000, pdc_ff};
                A_STATUS: s_axi_rdata <= {29'h0, demag_short_ff,
                    stage2_start_ok, ccm_turnon_ff};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_ERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks
    property p_sticky;
        @(posedge clk) disable iff (!nrst)
        (flt_ff[F_UV] && ack[F_UV] == 1'b0) |=> flt_ff[F_UV];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_restart;
        @(posedge clk) disable iff (!nrst)
        !cond_uv |=> cnt_uv_ff == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_uv;
        @(posedge clk) disable iff (!nrst)
        evt[F_UV] |=> flt_ff[F_UV];
    endproperty
    a_uv: assert property (p_uv) else $error("uv not set");
    property p_ov;
        @(posedge clk) disable iff (!nrst)
        $rose(flt_ff[F_OV]) |-> $past(cond_ov);
    endproperty
    a_ov: assert property (p_ov) else $error("ov spurious");
    property p_ccm;
        @(posedge clk) disable iff (!nrst)
        $rose(flt_ff[F_CCM]) |-> $past(ccm_turnon_ff);
    endproperty
    a_ccm: assert property (p_ccm) else $error("ccm spurious");
    property p_ss;
        @(posedge clk) disable iff (!nrst)
        $rose(flt_ff[F_SS]) |-> $past(ss_cnt_ff == ss_max_ff);
    endproperty
    a_ss: assert property (p_ss) else $error("ss spurious");
    sequence s_cycle;
        st_ff == ST_IDLE && fb_in.cycle_done;
    endsequence
    property p_valid;
        @(posedge clk) disable iff (!nrst)
        s_cycle |-> ##3 valid_ff;
    endproperty
    a_valid: assert property (p_valid) else $error("no result");
    property p_oc2;
        @(posedge clk) disable iff (!nrst)
        $rose(flt_ff[F_OC2]) |-> $past(cond_oc2);
    endproperty
    a_oc2: assert property (p_oc2) else $error("oc2 spurious");
endmodule // pps_top

// >>> sim/pps_stage_model.sv
// Power stage model: rectified line, pfc sense and flyback cycle samples.
// Assumes the bench sets the command inputs just after a rising clock edge.
`timescale 1ns/1ps
module pps_stage_model
    import pps_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [15:0] vin_level,
    input wire logic [15:0] cs_level,
    input wire logic osc_on,
    input wire logic ss_run,
    input wire logic ss_done,
    input wire logic burst_on,
    output pps_pkg::pps_pfc_t pfc_out,
    output pps_pkg::pps_fb_t fb_out
);
    logic [7:0] cyc_ff;

    // Free running phase counter for the switching cycles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cyc_ff <= 8'h00;
        end else begin
            cyc_ff <= cyc_ff + 8'h01;
        end
    end

    // Pfc side: a shorted sense pin shows up as missing oscillation
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pfc_out <= '0;
        end else begin
            pfc_out.vin_rms <= vin_level;
            pfc_out.pfc_cs <= cs_level;
            pfc_out.zcd_osc <= osc_on && (cyc_ff[2:0] == 3'h0);
            pfc_out.max_period_on <= !osc_on && (cyc_ff[2:0] == 3'h0);
            pfc_out.ss_tick <= ss_run && (cyc_ff[1:0] == 2'h0);
            pfc_out.ss_done <= ss_done;
        end
    end

    // Flyback cycle every 32 clocks, demagnetization above the minimum
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fb_out <= '0;
        end else begin
            fb_out.cs_sample <= 16'h3000;
            fb_out.zcd_sample <= 16'h2000;
            fb_out.t_on <= 16'h0040;
            fb_out.t_demag <= 16'(DEMAG_MIN_CYC + 16);
            fb_out.t_period <= 16'h0200;
            fb_out.n_pulses <= 8'h04;
            fb_out.burst <= burst_on;
            fb_out.cycle_done <= (cyc_ff[4:0] == 5'h1F);
        end
    end
endmodule // pps_stage_model

// >>> sim/testbench.sv
// Self-checking bench: AXI4-Lite register access and protection scenarios.
// Assumes pps_top with its package and the power stage model.
`timescale 1ns/1ps
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import pps_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, stage2_start_ok, valley_skip, result_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd_val;
    logic [15:0] peak_current_trip_level, vout_value, iout_value;
    logic [NFLT-1:0] fault_flags;
    pps_pfc_t pfc_in;
    pps_fb_t fb_in;
    logic [15:0] vin_cmd = 16'h8000, cs_cmd = 16'h0000;
    logic osc_cmd = 1'b1, ss_run_cmd = 1'b0, ss_done_cmd = 1'b0;
    logic burst_cmd = 1'b0;
    int errors = 0, cmp_count = 0;
    logic [7:0] cfg_a [9] = '{A_VIN_UV, A_VIN_OV, A_START_MIN, A_START_MAX,
        A_BLANK_UV, A_BLANK_OV, A_BLANK_OC2, A_BLANK_CCM, A_SS_MAX};
    logic [15:0] cfg_v [9] = '{16'h4000, 16'hC000, 16'h5000, 16'hB000,
        16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0005};

    always #4 clk = ~clk;

    pps_top #(.DW(16)) pps_top_inst (.clk(clk), .nrst(nrst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pfc_in(pfc_in), .fb_in(fb_in),
        .peak_current_trip_level(peak_current_trip_level),
        .stage2_start_ok(stage2_start_ok), .valley_skip(valley_skip),
        .fault_flags(fault_flags), .vout_value(vout_value),
        .iout_value(iout_value), .result_valid(result_valid));

    pps_stage_model pps_stage_model_inst (.clk(clk), .nrst(nrst),
        .vin_level(vin_cmd), .cs_level(cs_cmd), .osc_on(osc_cmd),
        .ss_run(ss_run_cmd), .ss_done(ss_done_cmd), .burst_on(burst_cmd),
        .pfc_out(pfc_in), .fb_out(fb_in));

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic timed_out();
        errors++;
        $display("MISMATCH t=%0t wait ran out", $time);
        print_verdict();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100) timed_out();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100) timed_out();
    endtask

    // Register view and port view of one fault cause must agree
    task automatic fault_is(input int idx, input logic exp);
        rd(A_FAULT, rd_val, rsp);
        `CHECK(rd_val[idx], exp)
        `CHECK(fault_flags[idx], exp)
    endtask

    task automatic wait_result();
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            if (result_valid === 1'b1) break;
        end
        if (n == 300) timed_out();
    endtask

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            wr(cfg_a[i], {16'h0000, cfg_v[i]}, rsp);
            `CHECK(rsp, RESP_OK)
            rd(cfg_a[i], rd_val, rsp);
            `CHECK(rd_val, {16'h0000, cfg_v[i]})
        end
        wr(A_FAULT, 32'h0000001F, rsp);
        `CHECK(fault_flags, 5'h00)
        repeat (4) @(posedge clk);
        `CHECK(stage2_start_ok, 1'b1)
        vin_cmd <= 16'h4800;
        repeat (4) @(posedge clk);
        `CHECK(stage2_start_ok, 1'b0)
        vin_cmd <= 16'h8000;
        wr(A_TRIP, 32'h00001234, rsp);
        `CHECK(peak_current_trip_level, 16'h1234)
        wr(A_CTRL, 32'h00000001, rsp);
        `CHECK(valley_skip, 1'b1)
        wr(A_CTRL, 32'h00000000, rsp);
        `CHECK(valley_skip, 1'b0)
        wr(8'h80, 32'hFFFFFFFF, rsp);
        `CHECK(rsp, RESP_ERR)
        rd(8'h80, rd_val, rsp);
        `CHECK(rsp, RESP_ERR)
        `CHECK(rd_val, 32'h00000000)
        // Second overcurrent: below, short, broken and held excursions
        cs_cmd <= OC2_FIXED - 16'h0001;
        repeat (60) @(posedge clk);
        fault_is(F_OC2, 1'b0);
        cs_cmd <= OC2_FIXED;
        repeat (8) @(posedge clk);
        cs_cmd <= 16'h0000;
        fault_is(F_OC2, 1'b0);
        cs_cmd <= OC2_FIXED;
        repeat (12) @(posedge clk);
        cs_cmd <= 16'h0000;
        @(posedge clk);
        cs_cmd <= OC2_FIXED;
        repeat (12) @(posedge clk);
        cs_cmd <= 16'h0000;
        fault_is(F_OC2, 1'b0);
        cs_cmd <= 16'hFFFF;
        repeat (60) @(posedge clk);
        cs_cmd <= 16'h0000;
        repeat (20) @(posedge clk);
        fault_is(F_OC2, 1'b1);
        wr(A_FAULT, 32'h1 << F_OC2, rsp);
        fault_is(F_OC2, 1'b0);
        // Input undervoltage and overvoltage
        vin_cmd <= 16'h3000;
        repeat (8) @(posedge clk);
        vin_cmd <= 16'h8000;
        fault_is(F_UV, 1'b0);
        vin_cmd <= 16'h3000;
        repeat (60) @(posedge clk);
        vin_cmd <= 16'h8000;
        fault_is(F_UV, 1'b1);
        vin_cmd <= 16'hD000;
        repeat (60) @(posedge clk);
        vin_cmd <= 16'h8000;
        fault_is(F_OV, 1'b1);
        wr(A_FAULT, 32'h0000001F, rsp);
        // Missing oscillation during soft start, then in steady state
        osc_cmd <= 1'b0;
        ss_run_cmd <= 1'b1;
        repeat (60) @(posedge clk);
        ss_run_cmd <= 1'b0;
        fault_is(F_CCM, 1'b0);
        fault_is(F_SS, 1'b1);
        // Soft start ends first so the clear is not beaten by the event
        ss_done_cmd <= 1'b1;
        wr(A_FAULT, 32'h1 << F_SS, rsp);
        repeat (60) @(posedge clk);
        fault_is(F_CCM, 1'b1);
        osc_cmd <= 1'b1;
        // Let an oscillation pulse end the conduction guard before clearing
        repeat (16) @(posedge clk);
        wr(A_FAULT, 32'h1 << F_CCM, rsp);
        fault_is(F_SS, 1'b0);
        fault_is(F_CCM, 1'b0);
        // Flyback: gain x2, on-time offset 16, delay comp 64, offset 16
        wr(A_SCALE, 32'h00002010, rsp);
        wr(A_PDC, 32'h00000040, rsp);
        wr(A_VOUT_OFS, 32'h00000010, rsp);
        wait_result();
        wait_result();
        `CHECK(vout_value, 16'h4010)
        `CHECK(iout_value, 16'h2140)
        rd(A_VOUT, rd_val, rsp);
        `CHECK(rd_val, 32'h00004010)
        rd(A_IOUT, rd_val, rsp);
        `CHECK(rd_val, 32'h00002140)
        rd(A_IPK, rd_val, rsp);
        `CHECK(rd_val, 32'h00008000)
        `CHECK(rsp, RESP_OK)
        burst_cmd <= 1'b1;
        wait_result();
        wait_result();
        `CHECK(iout_value, 16'h8500)
        print_verdict();
    end
endmodule // testbench
